//--- rtl/pfw_pkg.sv
// Constants, opcodes and state codes of the processor flags word logic
package pfw_pkg;
    localparam int unsigned WORD_W = 16;
    localparam int unsigned BYTE_W = 8;
    // Flag bit positions
    localparam int unsigned CARRY_BIT = 0;
    localparam int unsigned PARITY_BIT = 2;
    localparam int unsigned NIBBLE_BIT = 4;
    localparam int unsigned ZERO_BIT = 6;
    localparam int unsigned SIGN_BIT = 7;
    localparam int unsigned TRAP_BIT = 8;
    localparam int unsigned INT_EN_BIT = 9;
    localparam int unsigned DIR_BIT = 10;
    localparam int unsigned OVFL_BIT = 11;
    localparam int unsigned NIBBLE_TOP = 3;
    // Implemented bits; the rest read as zero
    localparam logic [15:0] FLAGS_IMPL_MASK = 16'h0FD5;
    localparam logic [15:0] STATUS_MASK = 16'h08D5;
    localparam logic [7:0] LOW_STATUS_MASK = 8'hD5;
    localparam logic [15:0] FLAGS_RESET = 16'h0000;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    // Flags stack
    localparam int unsigned STACK_DEPTH = 8;
    localparam int unsigned STACK_AW = 3;
    localparam int unsigned STACK_CW = 4;
    localparam logic [3:0] STACK_FULL_COUNT = 4'h8;
    localparam logic [3:0] STACK_ONE = 4'h1;
    localparam logic [3:0] STACK_EMPTY_COUNT = 4'h0;

    typedef enum logic [4:0] {
        OP_NOP = 5'h00,
        OP_ADD = 5'h01,
        OP_ADC = 5'h02,
        OP_SUB = 5'h03,
        OP_SUB_BRW = 5'h04,
        OP_AND = 5'h05,
        OP_OR = 5'h06,
        OP_XOR = 5'h07,
        OP_ROT_LEFT = 5'h08,
        OP_ROT_RIGHT = 5'h09,
        OP_CARRY_SET = 5'h0A,
        OP_CARRY_CLR = 5'h0B,
        OP_CARRY_INV = 5'h0C,
        OP_DIR_SET = 5'h0D,
        OP_DIR_CLR = 5'h0E,
        OP_IEN_SET = 5'h0F,
        OP_IEN_CLR = 5'h10,
        OP_FLAGS_OUT = 5'h11,
        OP_FLAGS_IN = 5'h12,
        OP_FLAGS_PUSH = 5'h13,
        OP_FLAGS_POP = 5'h14
    } pfw_op_e;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_POP_WAIT = 1'b1
    } pfw_state_e;
endpackage

//--- rtl/pfw_flags_stack.sv
// Small flags stack memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module pfw_flags_stack (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic push,
    input wire logic pop,
    input wire logic [15:0] push_data,
    output logic [15:0] pop_data,
    output logic empty,
    output logic full
);
    typedef struct packed {
        logic [pfw_pkg::STACK_CW-1:0] count;
        logic [15:0] rd_data;
    } pfw_stack_s;

    pfw_stack_s st;
    pfw_stack_s next_st;
    logic [15:0] mem [pfw_pkg::STACK_DEPTH];
    logic [pfw_pkg::STACK_AW-1:0] wr_addr;
    logic [pfw_pkg::STACK_AW-1:0] rd_addr;

    assign wr_addr = st.count[pfw_pkg::STACK_AW-1:0];
    assign rd_addr = 3'(st.count - pfw_pkg::STACK_ONE);
    assign empty = (st.count == pfw_pkg::STACK_EMPTY_COUNT);
    assign full = (st.count == pfw_pkg::STACK_FULL_COUNT);
    assign pop_data = st.rd_data;

    always_comb begin
        next_st = st;
        if (push && !full) begin
            next_st.count = st.count + pfw_pkg::STACK_ONE;
        end else if (pop && !empty) begin
            next_st.count = st.count - pfw_pkg::STACK_ONE;
            next_st.rd_data = mem[rd_addr];
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (push && !full) begin
            mem[wr_addr] <= push_data;
        end
    end
endmodule
`default_nettype wire

//--- rtl/pfw_flags_word.sv
// Flags word register, flag computation and flag instructions
// Operation
// RULE_01: Flags word is 16 bits; status at 0,2,4,6,7,11, control at 8,9,10.
// RULE_02: Carry set on carry or borrow out of the top bit, else cleared.
// RULE_03: Parity set when low result byte holds an even count of ones.
// RULE_04: Nibble carry set on carry out of or borrow into bit 3.
// RULE_05: Zero set when every result bit is zero.
// RULE_06: Sign takes the top bit of the result.
// RULE_07: Overflow set when signed result does not fit the destination.
// RULE_08: Trap bit raises single-step interrupt after next instruction, which clears it.
// RULE_09: Interrupt enable set lets maskable requests be taken; clear blocks them.
// RULE_10: Direction set makes string indexes decrement, clear makes them increment.
// RULE_11: Set and clear interrupt enable ops change only that flag.
// RULE_12: Load high byte op copies flags low byte to accumulator high byte.
// RULE_13: Store high byte op writes accumulator high byte into flags low byte.
// RULE_14: Push flags writes whole word to stack; pop reloads it.
// RULE_15: Add with carry adds both operands plus carry, then updates status.
// RULE_16: Subtract with borrow subtracts source and carry, then updates status.
// RULE_17: Rotates through carry include carry as an extra bit position.
// RULE_18: Single-flag ops set, clear or invert carry and set or clear direction.
`timescale 1ns/1ps
`default_nettype none
module pfw_flags_word (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic op_valid,
    input wire logic [4:0] op_code,
    input wire logic op_word,
    input wire logic [15:0] operand_dst,
    input wire logic [15:0] operand_src,
    input wire logic [7:0] accumulator_high_byte_in,
    input wire logic int_request,
    input wire logic [7:0] int_vector,
    output logic op_ready,
    output logic [15:0] status_flags_word,
    output logic [15:0] result,
    output logic result_valid,
    output logic [7:0] accumulator_high_byte,
    output logic accumulator_high_valid,
    output logic single_step_irq,
    output logic int_taken,
    output logic [7:0] int_vector_taken,
    output logic string_decrement,
    output logic stack_error
);
    typedef struct packed {
        pfw_pkg::pfw_state_e state;
        logic ready;
        logic trap_pend;
        logic [15:0] flags;
        logic [15:0] result;
        logic result_valid;
        logic full_update;
        logic res_word;
        logic [7:0] acc_high;
        logic acc_high_valid;
        logic ss_irq;
        logic int_taken;
        logic [7:0] vector;
        logic stack_error;
    } pfw_core_s;

    pfw_core_s st;
    pfw_core_s next_st;
    logic stk_push;
    logic stk_pop;
    logic [15:0] stk_data;
    logic stk_empty;
    logic stk_full;
    logic accept;
    pfw_pkg::pfw_op_e op;

    ////////////////////////////////////////////////////////////////////
    function automatic logic pfw_msb(input logic [16:0] v, input logic word);
        pfw_msb = word ? v[pfw_pkg::WORD_W-1] : v[pfw_pkg::BYTE_W-1];
    endfunction

    // RULE_03 even parity
    function automatic logic pfw_parity(input logic [15:0] v);
        pfw_parity = ~^v[pfw_pkg::BYTE_W-1:0];
    endfunction

    // Status bits from a result; control bits kept
    function automatic logic [15:0] pfw_status(
        input logic [15:0] old,
        input logic [15:0] res,
        input logic word,
        input logic carry_out,
        input logic nib_carry,
        input logic ovf
    );
        logic [15:0] f;
        f = old;
        f[pfw_pkg::CARRY_BIT] = carry_out;
        f[pfw_pkg::PARITY_BIT] = pfw_parity(res);
        f[pfw_pkg::NIBBLE_BIT] = nib_carry;
        f[pfw_pkg::ZERO_BIT] = (res == pfw_pkg::WORD_ZERO);
        // RULE_06 sign from msb
        f[pfw_pkg::SIGN_BIT] = pfw_msb({1'b0, res}, word);
        f[pfw_pkg::OVFL_BIT] = ovf;
        pfw_status = f;
    endfunction

    ////////////////////////////////////////////////////////////////////
    assign op = pfw_pkg::pfw_op_e'(op_code);
    assign accept = op_valid && st.ready;
    assign stk_push = accept && (op == pfw_pkg::OP_FLAGS_PUSH);
    assign stk_pop = accept && (op == pfw_pkg::OP_FLAGS_POP);

    pfw_flags_stack u_stack (
        .clk_sys(clk_sys),
        .reset(reset),
        .push(stk_push),
        .pop(stk_pop),
        .push_data(st.flags),
        .pop_data(stk_data),
        .empty(stk_empty),
        .full(stk_full)
    );

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [15:0] a;
        logic [15:0] b;
        logic [16:0] ext;
        logic [15:0] res;
        logic cin;
        logic sa;
        logic sb;
        logic sr;
        logic cf_new;
        logic done;
        logic trap_before;
        a = op_word ? operand_dst : {pfw_pkg::BYTE_ZERO, operand_dst[7:0]};
        b = op_word ? operand_src : {pfw_pkg::BYTE_ZERO, operand_src[7:0]};
        cin = 1'b0;
        ext = '0;
        res = '0;
        cf_new = 1'b0;
        sa = pfw_msb({1'b0, a}, op_word);
        sb = pfw_msb({1'b0, b}, op_word);
        done = 1'b0;
        trap_before = 1'b0;
        sr = 1'b0;
        next_st = st;
        next_st.result_valid = 1'b0;
        next_st.full_update = 1'b0;
        next_st.acc_high_valid = 1'b0;
        next_st.ss_irq = 1'b0;
        next_st.int_taken = 1'b0;
        next_st.stack_error = 1'b0;
        case (st.state)
            pfw_pkg::ST_IDLE: begin
                if (accept) begin
                    done = (op != pfw_pkg::OP_FLAGS_POP) || stk_empty;
                    trap_before = st.flags[pfw_pkg::TRAP_BIT];
                    next_st.trap_pend = st.flags[pfw_pkg::TRAP_BIT];
                    next_st.res_word = op_word;
                    case (op)
                        // RULE_15 add with carry
                        pfw_pkg::OP_ADD, pfw_pkg::OP_ADC: begin
                            if (op == pfw_pkg::OP_ADC) begin
                                cin = st.flags[pfw_pkg::CARRY_BIT];
                            end
                            ext = {1'b0, a} + {1'b0, b} + {16'h0000, cin};
                            res = op_word ? ext[15:0] : {pfw_pkg::BYTE_ZERO, ext[7:0]};
                            sr = pfw_msb(ext, op_word);
                            // RULE_02 carry out of top bit
                            cf_new = op_word ? ext[pfw_pkg::WORD_W] : ext[pfw_pkg::BYTE_W];
                            // RULE_07 signed add overflow
                            next_st.flags = pfw_status(st.flags, res, op_word, cf_new,
                                a[pfw_pkg::NIBBLE_BIT] ^ b[pfw_pkg::NIBBLE_BIT]
                                ^ ext[pfw_pkg::NIBBLE_BIT], (sa == sb) && (sr != sa));
                            next_st.result = res;
                            next_st.result_valid = 1'b1;
                            next_st.full_update = 1'b1;
                        end
                        // RULE_16 subtract with borrow
                        pfw_pkg::OP_SUB, pfw_pkg::OP_SUB_BRW: begin
                            if (op == pfw_pkg::OP_SUB_BRW) begin
                                cin = st.flags[pfw_pkg::CARRY_BIT];
                            end
                            ext = {1'b0, a} - {1'b0, b} - {16'h0000, cin};
                            res = op_word ? ext[15:0] : {pfw_pkg::BYTE_ZERO, ext[7:0]};
                            sr = pfw_msb(ext, op_word);
                            // RULE_04 borrow into low nibble
                            next_st.flags = pfw_status(st.flags, res, op_word,
                                op_word ? ext[pfw_pkg::WORD_W] : ext[pfw_pkg::BYTE_W],
                                a[pfw_pkg::NIBBLE_BIT] ^ b[pfw_pkg::NIBBLE_BIT]
                                ^ ext[pfw_pkg::NIBBLE_BIT], (sa != sb) && (sr != sa));
                            next_st.result = res;
                            next_st.result_valid = 1'b1;
                            next_st.full_update = 1'b1;
                        end
                        // RULE_05 logic results: carry, overflow, nibble cleared
                        pfw_pkg::OP_AND, pfw_pkg::OP_OR, pfw_pkg::OP_XOR: begin
                            if (op == pfw_pkg::OP_AND) begin
                                res = a & b;
                            end else if (op == pfw_pkg::OP_OR) begin
                                res = a | b;
                            end else begin
                                res = a ^ b;
                            end
                            next_st.flags = pfw_status(st.flags, res, op_word,
                                1'b0, 1'b0, 1'b0);
                            next_st.result = res;
                            next_st.result_valid = 1'b1;
                            next_st.full_update = 1'b1;
                        end
                        // RULE_17 carry is an extra rotation bit
                        pfw_pkg::OP_ROT_LEFT: begin
                            cf_new = sa;
                            res = op_word ? {a[14:0], st.flags[pfw_pkg::CARRY_BIT]}
                                : {pfw_pkg::BYTE_ZERO, a[6:0], st.flags[pfw_pkg::CARRY_BIT]};
                            next_st.flags[pfw_pkg::CARRY_BIT] = cf_new;
                            next_st.flags[pfw_pkg::OVFL_BIT] = pfw_msb({1'b0, res}, op_word)
                                ^ cf_new;
                            next_st.result = res;
                            next_st.result_valid = 1'b1;
                        end
                        pfw_pkg::OP_ROT_RIGHT: begin
                            res = op_word ? {st.flags[pfw_pkg::CARRY_BIT], a[15:1]}
                                : {pfw_pkg::BYTE_ZERO, st.flags[pfw_pkg::CARRY_BIT], a[7:1]};
                            next_st.flags[pfw_pkg::CARRY_BIT] = a[0];
                            next_st.flags[pfw_pkg::OVFL_BIT] = op_word ? (res[15] ^ res[14])
                                : (res[7] ^ res[6]);
                            next_st.result = res;
                            next_st.result_valid = 1'b1;
                        end
                        // RULE_18 single-flag instructions
                        pfw_pkg::OP_CARRY_SET: next_st.flags[pfw_pkg::CARRY_BIT] = 1'b1;
                        pfw_pkg::OP_CARRY_CLR: next_st.flags[pfw_pkg::CARRY_BIT] = 1'b0;
                        pfw_pkg::OP_CARRY_INV: begin
                            next_st.flags[pfw_pkg::CARRY_BIT] = ~st.flags[pfw_pkg::CARRY_BIT];
                        end
                        pfw_pkg::OP_DIR_SET: next_st.flags[pfw_pkg::DIR_BIT] = 1'b1;
                        pfw_pkg::OP_DIR_CLR: next_st.flags[pfw_pkg::DIR_BIT] = 1'b0;
                        // RULE_11 interrupt enable only
                        pfw_pkg::OP_IEN_SET: next_st.flags[pfw_pkg::INT_EN_BIT] = 1'b1;
                        pfw_pkg::OP_IEN_CLR: next_st.flags[pfw_pkg::INT_EN_BIT] = 1'b0;
                        // RULE_12 flags low byte out
                        pfw_pkg::OP_FLAGS_OUT: begin
                            next_st.acc_high = st.flags[7:0];
                            next_st.acc_high_valid = 1'b1;
                        end
                        // RULE_13 status bits of low byte in
                        pfw_pkg::OP_FLAGS_IN: begin
                            next_st.flags[7:0] = accumulator_high_byte_in
                                & pfw_pkg::LOW_STATUS_MASK;
                        end
                        // RULE_14 push whole word
                        pfw_pkg::OP_FLAGS_PUSH: next_st.stack_error = stk_full;
                        pfw_pkg::OP_FLAGS_POP: begin
                            if (stk_empty) begin
                                next_st.stack_error = 1'b1;
                            end else begin
                                next_st.state = pfw_pkg::ST_POP_WAIT;
                            end
                        end
                        default: begin
                        end
                    endcase
                end else if (int_request && st.flags[pfw_pkg::INT_EN_BIT]) begin
                    // RULE_09 maskable request gated by enable
                    next_st.int_taken = 1'b1;
                    next_st.vector = int_vector;
                end
            end
            pfw_pkg::ST_POP_WAIT: begin
                // RULE_14 reload from stack
                next_st.flags = stk_data & pfw_pkg::FLAGS_IMPL_MASK;
                next_st.state = pfw_pkg::ST_IDLE;
                done = 1'b1;
                trap_before = st.trap_pend;
            end
            default: next_st.state = pfw_pkg::ST_IDLE;
        endcase
        // RULE_08 trap after the instruction completes
        if (done && trap_before) begin
            next_st.ss_irq = 1'b1;
            next_st.flags[pfw_pkg::TRAP_BIT] = 1'b0;
        end
        // RULE_01 unimplemented bits held at zero
        next_st.flags = next_st.flags & pfw_pkg::FLAGS_IMPL_MASK;
        next_st.ready = (next_st.state == pfw_pkg::ST_IDLE);
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st <= '0;
            st.flags <= pfw_pkg::FLAGS_RESET;
            st.ready <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////
    assign op_ready = st.ready;
    assign status_flags_word = st.flags;
    assign result = st.result;
    assign result_valid = st.result_valid;
    assign accumulator_high_byte = st.acc_high;
    assign accumulator_high_valid = st.acc_high_valid;
    assign single_step_irq = st.ss_irq;
    assign int_taken = st.int_taken;
    assign int_vector_taken = st.vector;
    // RULE_10 direction drives index stepping
    assign string_decrement = st.flags[pfw_pkg::DIR_BIT];
    assign stack_error = st.stack_error;

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_reserved_zero: assert property ( // RULE_01
        (status_flags_word & ~pfw_pkg::FLAGS_IMPL_MASK) == pfw_pkg::WORD_ZERO)
        else $error("reserved flag bit set");
    a_parity_even: assert property ( // RULE_03
        st.full_update |-> status_flags_word[pfw_pkg::PARITY_BIT] == ~^result[7:0])
        else $error("parity flag wrong");
    a_zero_result: assert property ( // RULE_05
        st.full_update |-> status_flags_word[pfw_pkg::ZERO_BIT] == (result == 16'h0000))
        else $error("zero flag wrong");
    a_sign_msb: assert property ( // RULE_06
        st.full_update |-> status_flags_word[pfw_pkg::SIGN_BIT]
            == (st.res_word ? result[15] : result[7]))
        else $error("sign flag wrong");
    a_step_trap: assert property ( // RULE_08
        accept && op != pfw_pkg::OP_FLAGS_POP && status_flags_word[pfw_pkg::TRAP_BIT]
        |=> single_step_irq && !status_flags_word[pfw_pkg::TRAP_BIT])
        else $error("single step trap missing");
    a_int_gate: assert property ( // RULE_09
        int_taken |-> $past(status_flags_word[pfw_pkg::INT_EN_BIT]) && $past(int_request))
        else $error("interrupt taken while disabled");
    a_cli_only: assert property ( // RULE_11
        accept && op == pfw_pkg::OP_IEN_CLR |=> !status_flags_word[pfw_pkg::INT_EN_BIT]
        && ((status_flags_word ^ $past(status_flags_word)) & 16'hFCFF) == 16'h0000)
        else $error("clear enable touched other flags");
    a_load_high_byte_from_flags_copy: assert property ( // RULE_12
        accept && op == pfw_pkg::OP_FLAGS_OUT |=> accumulator_high_valid
        && accumulator_high_byte == $past(status_flags_word[7:0]))
        else $error("flags low byte not copied");
    a_stc_sets: assert property ( // RULE_18
        accept && op == pfw_pkg::OP_CARRY_SET |=> status_flags_word[pfw_pkg::CARRY_BIT])
        else $error("set carry failed");
    a_pop_two: assert property ( // RULE_14
        accept && op == pfw_pkg::OP_FLAGS_POP && !stk_empty |=> !op_ready ##1 op_ready)
        else $error("pop timing wrong");

    c_adc: cover property (accept && op == pfw_pkg::OP_ADC
        && status_flags_word[pfw_pkg::CARRY_BIT]);
    c_pop: cover property (st.state == pfw_pkg::ST_POP_WAIT);
    c_trap: cover property (single_step_irq);
    c_int: cover property (int_taken);
endmodule
`default_nettype wire

//--- tb/pfw_int_source.sv
// Interrupt requester standing in for the processor's interrupt controller
`timescale 1ns/1ps
`default_nettype none
module pfw_int_source (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic raise,
    input wire logic [7:0] vec_in,
    input wire logic int_taken,
    output logic int_request,
    output logic [7:0] int_vector
);
    ////////////////////////////////////////////////////////////////
    // Hold request until taken, then spoil the released vector
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            int_request <= 1'b0;
            int_vector <= 8'h00;
        end else if (raise) begin
            int_request <= 1'b1;
            int_vector <= vec_in;
        end else if (int_taken) begin
            int_request <= 1'b0;
            int_vector <= ~int_vector;
        end
    end
endmodule
`default_nettype wire

//--- tb/processor_flags_word_logic_test.sv
// Self-checking bench of the flags word logic
`timescale 1ns/1ps
`default_nettype none
module processor_flags_word_logic_test;
    logic clk_sys, reset, op_valid, op_word, raise, int_request, op_ready, result_valid;
    logic [4:0] op_code;
    logic [15:0] operand_dst, operand_src, flags, result;
    logic [7:0] acc_hi_in, int_vector, vec_in, acc_hi_out, vec_taken;
    logic acc_hi_valid, step_irq, int_taken, str_dec, stack_error;
    int err_count = 0;
    int total_checks = 0;
    pfw_flags_word dut (.clk_sys(clk_sys), .reset(reset), .op_valid(op_valid),
        .op_code(op_code), .op_word(op_word), .operand_dst(operand_dst),
        .operand_src(operand_src), .accumulator_high_byte_in(acc_hi_in),
        .int_request(int_request), .int_vector(int_vector), .op_ready(op_ready),
        .status_flags_word(flags), .result(result), .result_valid(result_valid),
        .accumulator_high_byte(acc_hi_out), .accumulator_high_valid(acc_hi_valid),
        .single_step_irq(step_irq), .int_taken(int_taken), .int_vector_taken(vec_taken),
        .string_decrement(str_dec), .stack_error(stack_error));
    pfw_int_source partner (.clk_sys(clk_sys), .reset(reset), .raise(raise),
        .vec_in(vec_in), .int_taken(int_taken), .int_request(int_request),
        .int_vector(int_vector));
    ////////////////////////////////////////////////////////////////
    // Checking and closing
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Issue one op; returns settled 1 ns after the clock edge that takes it
    task automatic op(input logic [4:0] c, input logic w, input logic [15:0] d,
        input logic [15:0] s, input logic [7:0] a);
        @(posedge clk_sys);
        op_valid <= 1'b1;
        op_code <= c;
        op_word <= w;
        operand_dst <= d;
        operand_src <= s;
        acc_hi_in <= a;
        @(posedge clk_sys);
        op_valid <= 1'b0;
        #1;
    endtask
    // Raise a request and count how often it is taken
    task automatic irq(input logic [7:0] v, output int n);
        n = 0;
        @(posedge clk_sys);
        raise <= 1'b1;
        vec_in <= v;
        @(posedge clk_sys);
        raise <= 1'b0;
        repeat (6) begin
            @(posedge clk_sys);
            #1;
            if (int_taken === 1'b1) n++;
        end
    endtask
    ////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_arith();
        op(5'h01, 1'b0, 16'h00FF, 16'h0001, 8'h00);
        chk({result_valid, flags}, {1'b1, 16'h0055});
        chk(result, 16'h0000);
        op(5'h02, 1'b1, 16'h7FFF, 16'h0000, 8'h00);
        chk(result, 16'h8000);
        chk(flags, 16'h0894);
        op(5'h03, 1'b1, 16'h0000, 16'h0001, 8'h00);
        chk({result, flags}, {16'hFFFF, 16'h0095});
        op(5'h07, 1'b1, 16'hFFFF, 16'h0001, 8'h00);
        chk({result, flags}, {16'hFFFE, 16'h0080});
        op(5'h0A, 1'b0, 16'h0000, 16'h0000, 8'h00);
        op(5'h04, 1'b0, 16'h0000, 16'h0000, 8'h00);
        chk({result, flags}, {16'h00FF, 16'h0095});
        $display("arith done");
    endtask
    task automatic t_single();
        op(5'h0B, 1'b0, 16'h0, 16'h0, 8'h00);
        chk(flags, 16'h0094);
        op(5'h0C, 1'b0, 16'h0, 16'h0, 8'h00);
        chk(flags, 16'h0095);
        op(5'h0D, 1'b0, 16'h0, 16'h0, 8'h00);
        chk({str_dec, flags}, {1'b1, 16'h0495});
        op(5'h0E, 1'b0, 16'h0, 16'h0, 8'h00);
        chk({str_dec, flags}, {1'b0, 16'h0095});
        op(5'h08, 1'b0, 16'h0080, 16'h0, 8'h00);
        chk({result, flags[0]}, {16'h0001, 1'b1});
        op(5'h09, 1'b0, 16'h0001, 16'h0, 8'h00);
        chk({result, flags[0]}, {16'h0080, 1'b1});
        $display("single flag done");
    endtask
    task automatic t_transfer();
        op(5'h05, 1'b0, 16'h0000, 16'h0000, 8'h00);
        chk(flags, 16'h0044);
        op(5'h13, 1'b0, 16'h0, 16'h0, 8'h00);
        op(5'h12, 1'b0, 16'h0, 16'h0, 8'hFF);
        chk(flags, 16'h00D5);
        op(5'h11, 1'b0, 16'h0, 16'h0, 8'h00);
        chk({acc_hi_valid, acc_hi_out}, {1'b1, 8'hD5});
        op(5'h14, 1'b0, 16'h0, 16'h0, 8'h00);
        chk(op_ready, 1'b0);
        @(posedge clk_sys);
        #1;
        chk({op_ready, flags}, {1'b1, 16'h0044});
        op(5'h14, 1'b0, 16'h0, 16'h0, 8'h00);
        chk({stack_error, flags}, {1'b1, 16'h0044});
        repeat (8) op(5'h13, 1'b0, 16'h0, 16'h0, 8'h00);
        chk(stack_error, 1'b0);
        op(5'h13, 1'b0, 16'h0, 16'h0, 8'h00);
        chk({stack_error, flags}, {1'b1, 16'h0044});
        $display("transfer done");
    endtask
    task automatic t_irq();
        int n;
        irq(8'hA5, n);
        chk(n, 0);
        op(5'h0F, 1'b0, 16'h0, 16'h0, 8'h00);
        chk(flags, 16'h0244);
        irq(8'h5A, n);
        chk({n > 0, vec_taken}, {1'b1, 8'h5A});
        op(5'h10, 1'b0, 16'h0, 16'h0, 8'h00);
        chk(flags, 16'h0044);
        $display("interrupt done");
    endtask
    ////////////////////////////////////////////////////////////////
    // Clock, reset, sequence and watchdog
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    initial begin
        reset = 1'b1;
        {op_valid, op_word, raise, op_code, operand_dst, operand_src, acc_hi_in, vec_in} = '0;
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        #1;
        chk({op_ready, flags}, {1'b1, 16'h0000});
        t_arith();
        t_single();
        t_transfer();
        t_irq();
        stop_test();
    end
    initial begin
        repeat (3000) @(posedge clk_sys);
        err_count++;
        stop_test();
    end
endmodule
`default_nettype wire
